// ---- hw/wdr_defines.vh ----
// Constants for the watchdog, system reset and drive-strength control block.
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH
// ==========================================================================
// Register offsets on the byte-wide register port.
`define WDR_OFF_AUX_DRIVE 8'h07
`define WDR_OFF_IDENT 8'h08
`define WDR_OFF_RST_WD 8'h09
// ==========================================================================
// Field positions in aux_clock_drive_ctrl.
`define WDR_BIT_DUAL_RATE_DRV 6
`define WDR_BIT_USB_RATE_DRV 5
// Field positions in sys_reset_watchdog_ctrl.
`define WDR_BIT_MEM_DRV 7
`define WDR_BIT_PERIPH_DRV 6
`define WDR_BIT_RST_ON_TO 4
`define WDR_BIT_RST_ON_FC 3
`define WDR_BIT_TO_FLAG 2
`define WDR_BIT_GUARD_EN 1
`define WDR_BIT_PROC_DRV 0
// ==========================================================================
// Reset values.
`define WDR_RST_DUAL_RATE_DRV 1'b1
`define WDR_RST_USB_RATE_DRV 1'b1
`define WDR_RST_OTHER_BIT 1'b0
// Identification codes; both values are arbitrary.
`define WDR_REVISION_CODE 4'h5
`define WDR_MAKER_CODE 4'h3
// ==========================================================================
// Timing: clock rate, tick periods and reset pulse length.
`define WDR_CLK_KHZ 125000
`define WDR_TICK_SHORT_MS 150
`define WDR_TICK_LONG_MS 2500
// Tick periods in clock cycles, sized for the 29-bit tick counter.
`define WDR_TICK_SHORT_CYCLES 29'd18750000
`define WDR_TICK_LONG_CYCLES 29'd312500000
`define WDR_RST_PULSE_CYCLES 16
`endif

// ---- hw/wdr_tick_gen.v ----
// Watchdog tick generator with two selectable periods.
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defines.vh"
module wdr_tick_gen #(
   parameter CNT_W = 29,
   parameter [CNT_W-1:0] SHORT_CYCLES = 29'd18750000,
   parameter [CNT_W-1:0] LONG_CYCLES = 29'd312500000
) (
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   input wire restart_i,
   input wire long_sel_i,
   output reg tick_o
);
   reg [CNT_W-1:0] cnt_q;
   wire [CNT_W-1:0] period;

   // Period chosen by the tick select bit.
   assign period = long_sel_i ? LONG_CYCLES : SHORT_CYCLES;

   // ==========================================================================
   // Free count, restarted whenever the watchdog is not counting.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= {CNT_W{1'b0}};
         tick_o <= 1'b0;
      end else if (ce_i) begin
         tick_o <= 1'b0;
         if (restart_i) begin
            cnt_q <= {CNT_W{1'b0}};
         end else if (cnt_q >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            cnt_q <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // wdr_tick_gen
`default_nettype wire

// ---- hw/wdr_ctrl.v ----
// Drive strength, identification, watchdog and system reset control bytes.
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defines.vh"
// Contract
// - Byte 7 bits 6 and 5 select high drive for dual and usb outputs; reset 1.
// - Byte 9 bit 7 selects high drive for memory clocks; reset 0.
// - Byte 9 bit 6 selects high drive for peripheral bus clocks; reset 0.
// - Byte 9 bit 0 selects high drive for processor clocks; reset 0.
// - Identification byte is read-only; revision code in bits 7 to 4.
// - Identification bits 3 to 0 hold a fixed read-only maker code.
// - Bit 4 set makes a time-out produce a system reset pulse.
// - Bit 3 set makes a frequency change produce a system reset pulse, merged into any pulse already running.
// - Bit 2 flags a time-out; writing one clears it, zero ignored.
// - Clearing bit 1 stops, reloads the watchdog and leaves recovery mode.
// - With bit 1 set, counting starts only after a frequency change.
// - Expiry issues reset if bit 4 set, loads recovery frequency, locks recovery mode.
// - In recovery mode host frequency writes are ignored.
// - Counts down from five-bit value; at zero sets flag, resets if enabled.
// - Tick select picks 150 ms or 2.5 s per count unit.
module wdr_ctrl #(
   parameter [28:0] TICK_SHORT_CYCLES = `WDR_TICK_SHORT_CYCLES,
   parameter [28:0] TICK_LONG_CYCLES = `WDR_TICK_LONG_CYCLES,
   parameter [7:0] RST_PULSE_CYCLES = `WDR_RST_PULSE_CYCLES
) (
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   input wire [4:0] guard_timeout_count_i,
   input wire guard_tick_select_i,
   input wire freq_change_i,
   input wire freq_wr_attempt_i,
   output wire freq_wr_allow_o,
   output reg recovery_load_o,
   output wire recovery_mode_o,
   output reg sys_reset_o,
   output wire dual_rate_out_drive_high_o,
   output wire usb_rate_out_drive_high_o,
   output wire memory_clk_drive_high_o,
   output wire periph_bus_clk_drive_high_o,
   output wire proc_clk_drive_high_o
);
   reg dual_drv_q;
   reg usb_drv_q;
   reg mem_drv_q;
   reg periph_drv_q;
   reg proc_drv_q;
   reg rst_on_to_q;
   reg rst_on_fc_q;
   reg timeout_flag_q;
   reg guard_en_q;
   reg armed_q;
   reg locked_q;
   reg [4:0] count_q;
   reg [7:0] pulse_cnt_q;
   wire wr_aux;
   wire wr_rst;
   wire tick;
   wire expire;
   wire rst_req;
   wire to_clear;
   wire guard_stop;

   assign wr_aux = ce_i & reg_wr_i & (reg_addr_i == `WDR_OFF_AUX_DRIVE);
   assign wr_rst = ce_i & reg_wr_i & (reg_addr_i == `WDR_OFF_RST_WD);
   assign to_clear = wr_rst & reg_wdata_i[`WDR_BIT_TO_FLAG];

   // A write that clears the enable stops and unlocks at its own edge, not one cycle later.
   assign guard_stop = ~guard_en_q | (wr_rst & ~reg_wdata_i[`WDR_BIT_GUARD_EN]);

   // Drive-strength selections reach the output buffers directly.
   assign dual_rate_out_drive_high_o = dual_drv_q;
   assign usb_rate_out_drive_high_o = usb_drv_q;
   assign memory_clk_drive_high_o = mem_drv_q;
   assign periph_bus_clk_drive_high_o = periph_drv_q;
   assign proc_clk_drive_high_o = proc_drv_q;

   // Host frequency writes pass only outside recovery mode.
   assign recovery_mode_o = locked_q;
   assign freq_wr_allow_o = freq_wr_attempt_i & ~locked_q;

   // ==========================================================================
   // Tick source; held in restart while the countdown is idle.
   wdr_tick_gen #(
      .CNT_W(29),
      .SHORT_CYCLES(TICK_SHORT_CYCLES),
      .LONG_CYCLES(TICK_LONG_CYCLES)
   ) u_tick (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .restart_i(~armed_q),
      .long_sel_i(guard_tick_select_i),
      .tick_o(tick)
   );

   // Expiry on the tick that takes the count to zero; zero itself expires at once.
   assign expire = armed_q & guard_en_q & ((count_q == 5'h00) | (tick & (count_q == 5'h01)));

   // Either cause may request a reset; both share one pulse.
   assign rst_req = (expire & rst_on_to_q) | (freq_change_i & rst_on_fc_q);

   // ==========================================================================
   // Register storage for bytes 7 and 9.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         dual_drv_q <= `WDR_RST_DUAL_RATE_DRV;
         usb_drv_q <= `WDR_RST_USB_RATE_DRV;
         mem_drv_q <= `WDR_RST_OTHER_BIT;
         periph_drv_q <= `WDR_RST_OTHER_BIT;
         proc_drv_q <= `WDR_RST_OTHER_BIT;
         rst_on_to_q <= `WDR_RST_OTHER_BIT;
         rst_on_fc_q <= `WDR_RST_OTHER_BIT;
         guard_en_q <= `WDR_RST_OTHER_BIT;
      end else begin
         if (wr_aux) begin
            dual_drv_q <= reg_wdata_i[`WDR_BIT_DUAL_RATE_DRV];
            usb_drv_q <= reg_wdata_i[`WDR_BIT_USB_RATE_DRV];
         end
         if (wr_rst) begin
            mem_drv_q <= reg_wdata_i[`WDR_BIT_MEM_DRV];
            periph_drv_q <= reg_wdata_i[`WDR_BIT_PERIPH_DRV];
            proc_drv_q <= reg_wdata_i[`WDR_BIT_PROC_DRV];
            rst_on_to_q <= reg_wdata_i[`WDR_BIT_RST_ON_TO];
            rst_on_fc_q <= reg_wdata_i[`WDR_BIT_RST_ON_FC];
            guard_en_q <= reg_wdata_i[`WDR_BIT_GUARD_EN];
         end
      end
   end

   // ==========================================================================
   // Time-out flag: a new expiry wins over a clear in the same cycle.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         timeout_flag_q <= 1'b0;
      end else if (ce_i) begin
         if (expire) begin
            timeout_flag_q <= 1'b1;
         end else if (to_clear) begin
            timeout_flag_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Countdown, arming and the recovery lock.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         armed_q <= 1'b0;
         locked_q <= 1'b0;
         count_q <= 5'h00;
         recovery_load_o <= 1'b0;
      end else if (ce_i) begin
         recovery_load_o <= 1'b0;
         if (guard_stop) begin
            armed_q <= 1'b0;
            locked_q <= 1'b0;
            count_q <= guard_timeout_count_i;
         end else if (expire) begin
            armed_q <= 1'b0;
            locked_q <= 1'b1;
            recovery_load_o <= 1'b1;
            count_q <= guard_timeout_count_i;
         end else if (freq_change_i && !armed_q && !locked_q) begin
            armed_q <= 1'b1;
            count_q <= guard_timeout_count_i;
         end else if (armed_q && tick) begin
            count_q <= count_q - 5'h01;
         end
      end
   end

   // ==========================================================================
   // System reset pulse of fixed length; requests during a pulse merge into it.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pulse_cnt_q <= 8'h00;
         sys_reset_o <= 1'b0;
      end else if (ce_i) begin
         if (rst_req && pulse_cnt_q == 8'h00) begin
            pulse_cnt_q <= RST_PULSE_CYCLES;
            sys_reset_o <= 1'b1;
         end else if (pulse_cnt_q == 8'h01) begin
            pulse_cnt_q <= 8'h00;
            sys_reset_o <= 1'b0;
         end else if (pulse_cnt_q != 8'h00) begin
            pulse_cnt_q <= pulse_cnt_q - 8'h01;
         end
      end
   end

   // ==========================================================================
   // Read data, registered; unmapped offsets read zero.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         case (reg_addr_i)
            `WDR_OFF_AUX_DRIVE: begin
               reg_rdata_o <= {1'b0, dual_drv_q, usb_drv_q, 5'h00};
            end
            `WDR_OFF_IDENT: begin
               reg_rdata_o <= {`WDR_REVISION_CODE, `WDR_MAKER_CODE};
            end
            `WDR_OFF_RST_WD: begin
               reg_rdata_o <= {mem_drv_q, periph_drv_q, 1'b0, rst_on_to_q, rst_on_fc_q,
                               timeout_flag_q, guard_en_q, proc_drv_q};
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end
   end
endmodule // wdr_ctrl
`default_nettype wire

// ---- testbench/wdr_synth_model.sv ----
// Behavioural model of the synthesizer core that applies host frequency writes.
`timescale 1ns/10ps
`default_nettype none
module wdr_synth_model (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic apply_i,
   output var logic changed_o
);
   // An allowed write retunes the outputs and reports the change one cycle later.
   always_ff @(posedge sys_clk_i) begin
      changed_o <= !sys_rst_i && apply_i;
   end
endmodule // wdr_synth_model
`default_nettype wire

// ---- testbench/wdr_ctrl_asserts.sv ----
// Port assertions for the watchdog and reset control block.
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defines.vh"
module wdr_ctrl_chk #(parameter [7:0] RST_PULSE_CYCLES = 8'h10) (
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire freq_change_i,
   input wire freq_wr_attempt_i,
   input wire freq_wr_allow_o,
   input wire recovery_load_o,
   input wire recovery_mode_o,
   input wire sys_reset_o,
   input wire memory_clk_drive_high_o,
   input wire periph_bus_clk_drive_high_o,
   input wire proc_clk_drive_high_o
);
   // =========================================================================
   // Helper logic: a write to the reset byte and the length of a reset pulse.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic wr_rst = ce_i && reg_wr_i && reg_addr_i == 8'h09;
   logic [7:0] hi_q;
   always_ff @(posedge sys_clk_i) begin
      hi_q <= (sys_rst_i || !sys_reset_o) ? 8'h00 : hi_q + (ce_i ? 8'h01 : 8'h00);
   end
   // Locking, gating, reset pulse, identification read and drive write relations.
   a_allow_gate: assert property (freq_wr_allow_o == (freq_wr_attempt_i && !recovery_mode_o))
      else $error("frequency write gate wrong");
   a_unlock_clear: assert property (wr_rst && !reg_wdata_i[1] |=> !recovery_mode_o)
      else $error("recovery mode kept after enable cleared");
   a_lock_holds: assert property (recovery_mode_o && !(wr_rst && !reg_wdata_i[1]) |=> recovery_mode_o)
      else $error("recovery mode left without unlock");
   a_lock_load: assert property (recovery_load_o |-> ##[0:1] recovery_mode_o)
      else $error("recovery load without lock");
   a_reset_cause: assert property ($rose(sys_reset_o) |-> $past(freq_change_i) || $past(recovery_load_o)
      || recovery_load_o)
      else $error("system reset without cause");
   a_pulse_len: assert property ($fell(sys_reset_o) |-> hi_q == RST_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   a_pulse_max: assert property (sys_reset_o |-> hi_q < RST_PULSE_CYCLES)
      else $error("reset pulse too long");
   a_ident_read: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h08
      |=> reg_rdata_o == {`WDR_REVISION_CODE, `WDR_MAKER_CODE})
      else $error("identification byte wrong");
   a_drive_write: assert property (wr_rst |=> {memory_clk_drive_high_o, periph_bus_clk_drive_high_o,
      proc_clk_drive_high_o} == {$past(reg_wdata_i[7:6]), $past(reg_wdata_i[0])})
      else $error("drive outputs not updated");
endmodule // wdr_ctrl_chk
bind wdr_ctrl wdr_ctrl_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) wdr_ctrl_chk_i (.*);
`default_nettype wire

// ---- testbench/wdr_ctrl_test.sv ----
// Self-checking testbench for the watchdog and reset control block.
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defines.vh"
module wdr_ctrl_test;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
   logic [4:0] guard_timeout_count_i = 5'h03;
   logic guard_tick_select_i = 1'b0, freq_wr_attempt_i = 1'b0, rs, rl;
   wire logic freq_change_i, freq_wr_allow_o, recovery_load_o, recovery_mode_o, sys_reset_o;
   wire logic [7:0] reg_rdata_o;
   wire logic dual_rate_out_drive_high_o, usb_rate_out_drive_high_o, memory_clk_drive_high_o;
   wire logic periph_bus_clk_drive_high_o, proc_clk_drive_high_o;
   int n_mismatch = 0, checks_done = 0, n;
   // =========================================================================
   // Design, synthesizer model and clock; ticks are shortened to 20 and 50 cycles.
   wdr_ctrl #(.TICK_SHORT_CYCLES(29'd20), .TICK_LONG_CYCLES(29'd50), .RST_PULSE_CYCLES(8'h04)) wdr_ctrl_i (.*);
   wdr_synth_model wdr_synth_model_i (.sys_clk_i, .sys_rst_i, .apply_i(freq_wr_allow_o), .changed_o(freq_change_i));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   // Shared helpers: cycle wait, compare, register access and frequency change.
   task automatic tk(input int c);
      repeat (c) @(posedge sys_clk_i) #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      tk(1);
      reg_wr_i = 1'b0;
      tk(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      tk(1);
      reg_rd_i = 1'b0;
      chk(reg_rdata_o, e);
      tk(1);
   endtask
   task automatic fc(input logic e);
      freq_wr_attempt_i = 1'b1;
      #1 chk(8'(freq_wr_allow_o), 8'(e));
      tk(1);
      freq_wr_attempt_i = 1'b0;
      tk(1);
   endtask
   // Counts the reset cycles seen in a fixed window of twelve cycles.
   task automatic pulse_len(input logic [7:0] e);
      n = 0;
      repeat (12) begin
         if (sys_reset_o === 1'b1) begin
            n++;
         end
         tk(1);
      end
      chk(8'(n), e);
   endtask
   task automatic wait_lock(input int lo, input int hi);
      n = 0;
      rs = 1'b0;
      rl = 1'b0;
      while (recovery_mode_o !== 1'b1 && n < 400) begin
         tk(1);
         n++;
         rs = rs | sys_reset_o;
         rl = rl | recovery_load_o;
      end
      chk(8'(n >= lo && n <= hi), 8'h01);
      if (n >= 400) complete_run();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      tk(3);
      sys_rst_i = 1'b0;
      rd(8'h07, 8'h60);
      rd(8'h09, 8'h00);
      wr(8'h08, 8'h00);
      rd(8'h08, {`WDR_REVISION_CODE, `WDR_MAKER_CODE});
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h60);
      wr(8'h07, 8'h00);
      chk(8'({dual_rate_out_drive_high_o, usb_rate_out_drive_high_o}), 8'h00);
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
      wr(8'h09, 8'hc1);
      chk(8'({memory_clk_drive_high_o, periph_bus_clk_drive_high_o, proc_clk_drive_high_o}), 8'h07);
      ce_i = 1'b0;
      wr(8'h09, 8'h00);
      ce_i = 1'b1;
      rd(8'h09, 8'hc1);
      $display("test registers done");
      wr(8'h09, 8'h08);
      fc(1'b1);
      pulse_len(8'h04);
      wr(8'h09, 8'h00);
      fc(1'b1);
      pulse_len(8'h00);
      $display("test change reset done");
      wr(8'h09, 8'h12);
      tk(150);
      rd(8'h09, 8'h12);
      fc(1'b1);
      wait_lock(58, 64);
      chk(8'(rs), 8'h01);
      chk(8'(rl), 8'h01);
      rd(8'h09, 8'h16);
      wr(8'h09, 8'h1a);
      fc(1'b0);
      pulse_len(8'h00);
      rd(8'h09, 8'h1e);
      wr(8'h09, 8'h16);
      rd(8'h09, 8'h12);
      chk(8'(recovery_mode_o), 8'h01);
      wr(8'h09, 8'h00);
      chk(8'(recovery_mode_o), 8'h00);
      $display("test short watchdog done");
      guard_tick_select_i = 1'b1;
      guard_timeout_count_i = 5'h01;
      wr(8'h09, 8'h02);
      fc(1'b1);
      wait_lock(48, 54);
      chk(8'(rs), 8'h00);
      chk(8'(rl), 8'h01);
      wr(8'h09, 8'h00);
      $display("test long watchdog done");
      complete_run();
   end
endmodule // wdr_ctrl_test
`default_nettype wire
